// ===== include/dmc_params.svh
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH

// ----------------------------------------
// Register map, global block.
// ----------------------------------------
`define DMC_G_CTRL   4'h0
`define DMC_G_STAT   4'h1
`define DMC_G_MASK   4'h2
`define DMC_G_BUSY   4'h3

// ----------------------------------------
// Register map, per channel (window 8'h10 * (n + 1)).
// ----------------------------------------
`define DMC_C_CTRL   4'h0
`define DMC_C_AMODE  4'h1
`define DMC_C_TSEL   4'h2
`define DMC_C_CNTL   4'h3
`define DMC_C_CNTH   4'h4
`define DMC_C_REP    4'h5
`define DMC_C_SRCL   4'h6
`define DMC_C_SRCH   4'h7
`define DMC_C_DSTL   4'h8
`define DMC_C_DSTH   4'h9

// ----------------------------------------
// Field positions.
// ----------------------------------------
`define DMC_F_EN     0
`define DMC_F_RPT    1
`define DMC_F_SWRQ   2
`define DMC_F_LINK   3
`define DMC_F_BL     5:4
`define DMC_F_SMODE  1:0
`define DMC_F_SRLD   2
`define DMC_F_DMODE  5:4
`define DMC_F_DRLD   6
`define DMC_F_GEN    0
`define DMC_F_RR     1
`define DMC_F_TEVT   7
`define DMC_F_TPER   6
`define DMC_F_TIDX   2:0

// ----------------------------------------
// Reset values and protected data-space windows.
// ----------------------------------------
`define DMC_RST8     8'h00
`define DMC_RST16    16'h0000
`define DMC_EE_LO    16'h1000
`define DMC_EE_HI    16'h1FFF
`define DMC_FL_LO    16'hF000
`define DMC_FL_HI    16'hFFFF

`endif

// ===== include/dmc_pkg.sv
package dmc_pkg;

	// Engine states, Gray coded along idle-read-wait-latch-write.
	typedef enum logic [2:0] {
		st_idle  = 3'h0,
		st_rd    = 3'h1,
		st_rwait = 3'h3,
		st_latch = 3'h2,
		st_wr    = 3'h6
	} dmc_state_type;

	// Address stepping modes.
	typedef enum logic [1:0] {
		am_fixed = 2'h0,
		am_inc   = 2'h1,
		am_dec   = 2'h2
	} dmc_amode_type;

endpackage

// ===== verilog/dmc_arb.sv
`timescale 1ns/1ps

// Picks one requesting channel, fixed (channel 0 first) or round robin.
module dmc_arb (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	// Requests and mode.
	input  wire logic [3:0] req,
	input  wire logic       rr_mode,
	input  wire logic       take,
	// Grant.
	output logic      [1:0] gnt,
	output logic            vld
);

	logic [1:0] last_r;

	// Returns the first set request at or after the start index.
	function automatic logic [1:0] pick(input logic [3:0] r, input logic [1:0] start);
		logic [1:0] k;
		pick = start;
		for (int i = 3; i >= 0; i--) begin
			k = start + 2'(i);
			if (r[k])
				pick = k;
		end
	endfunction

	// ----------------------------------------
	// Selection.
	// ----------------------------------------
	// Round robin starts just past the last winner so no channel starves.
	wire [1:0] start = rr_mode ? last_r + 2'h1 : 2'h0;
	assign gnt = pick(req, start); // [R7]
	assign vld = |req;

	// Remember the last channel actually served.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			last_r <= 2'h0;
		else if (take)
			last_r <= gnt;
	end

	fixed_order_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R7]
		(vld && !rr_mode && req[0]) |-> gnt == 2'h0)
		else $error("fixed priority did not favour channel zero");

	rr_rotates_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R7]
		(vld && rr_mode && req[last_r + 2'h1]) |-> gnt == last_r + 2'h1)
		else $error("round robin skipped the next channel");

endmodule

// ===== verilog/dmc_core.sv
`timescale 1ns/1ps
`include "dmc_params.svh"

// Summary of operation
// [R1] Four channels, each independently configured.
// [R2] Block length one byte to 64K.
// [R3] Repeat counter extends transaction to 16M.
// [R4] Source, destination step inc, dec, fixed.
// [R5] Optional address reload at transaction end.
// [R6] Burst of 1, 2, 4 or 8 bytes.
// [R7] Software-programmable channel priority.
// [R8] Linked pair hands over on completion.
// [R9] Mapped EEPROM read only, flash never.
// [R10] Transfers share the processor data bus.
// [R11] Peripheral, event or software triggers.
// [R12] Any data-space address as source/destination.
// [R13] Deterministic core versus DMA bus arbitration.
// [R14] Completion flags, clears busy, stops requesting.
// [R15] Forbidden target flags error, aborts.
module dmc_core (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Register port.
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Triggers.
	input  wire logic [7:0]  evt_trig,
	input  wire logic [31:0] per_trig,
	// Shared data bus.
	input  wire logic        cpu_req,
	input  wire logic        ee_mapped,
	input  wire logic [7:0]  bus_rdata,
	output logic      [15:0] bus_addr,
	output logic      [7:0]  bus_wdata,
	output logic             bus_wr,
	output logic             bus_rd,
	output logic             dma_own,
	// Interrupt.
	output logic             irq
);

	// ----------------------------------------
	// Functions.
	// ----------------------------------------
	function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m);
		step = (m == dmc_pkg::am_inc) ? a + 16'h0001 : (m == dmc_pkg::am_dec) ? a - 16'h0001 : a;
	endfunction

	function automatic logic in_ee(input logic [15:0] a);
		in_ee = a >= `DMC_EE_LO && a <= `DMC_EE_HI;
	endfunction

	function automatic logic in_fl(input logic [15:0] a);
		in_fl = a >= `DMC_FL_LO && a <= `DMC_FL_HI;
	endfunction

	function automatic logic trig_hit(input logic [7:0] sel, input logic [7:0] ev, input logic [7:0] pt);
		trig_hit = (sel[`DMC_F_TEVT] & ev[sel[`DMC_F_TIDX]]) | (sel[`DMC_F_TPER] & pt[sel[`DMC_F_TIDX]]);
	endfunction

	// ----------------------------------------
	// State.
	// ----------------------------------------
	logic [7:0]  ctl_r  [4];
	logic [7:0]  amc_r  [4];
	logic [7:0]  tsel_r [4];
	logic [15:0] bk_r   [4];
	logic [15:0] cnt_r  [4];
	logic [7:0]  rp_r   [4];
	logic [7:0]  rep_r  [4];
	logic [15:0] sa0_r  [4];
	logic [15:0] sa_r   [4];
	logic [15:0] da0_r  [4];
	logic [15:0] da_r   [4];
	logic [3:0]  pend_r;
	logic [7:0]  gctl_r;
	logic [7:0]  stat_r;
	logic [7:0]  mask_r;
	logic [7:0]  rdata_r;
	logic        irq_r;
	logic        turn_r;
	logic [1:0]  ch_r;
	logic [3:0]  bl_r;
	logic [7:0]  data_r;
	logic [15:0] ba_r;
	logic [7:0]  bd_r;
	logic        bw_r;
	logic        brd_r;
	logic        own_r;
	dmc_pkg::dmc_state_type st_r;

	// ----------------------------------------
	// Register decode.
	// ----------------------------------------
	wire       g_hit = reg_addr[7:4] == 4'h0;
	wire [3:0] c_num = reg_addr[7:4] - 4'h1;
	wire       c_hit = reg_addr[7:4] >= 4'h1 && reg_addr[7:4] <= 4'h4;
	wire [1:0] c_ix  = c_num[1:0];
	wire [3:0] off   = reg_addr[3:0];
	wire       g_wr  = reg_wr && g_hit;

	// Channel read view; CTRL bit 7 shows the channel still owes bytes.
	wire [7:0] c_word =
		(off == `DMC_C_CTRL)  ? {ctl_r[c_ix][`DMC_F_EN], ctl_r[c_ix][6:3], 1'b0, ctl_r[c_ix][1:0]} :
		(off == `DMC_C_AMODE) ? amc_r[c_ix] :
		(off == `DMC_C_TSEL)  ? tsel_r[c_ix] :
		(off == `DMC_C_CNTL)  ? cnt_r[c_ix][7:0] :
		(off == `DMC_C_CNTH)  ? cnt_r[c_ix][15:8] :
		(off == `DMC_C_REP)   ? rep_r[c_ix] :
		(off == `DMC_C_SRCL)  ? sa_r[c_ix][7:0] :
		(off == `DMC_C_SRCH)  ? sa_r[c_ix][15:8] :
		(off == `DMC_C_DSTL)  ? da_r[c_ix][7:0] :
		(off == `DMC_C_DSTH)  ? da_r[c_ix][15:8] : 8'h00;

	wire [3:0] en_v = {ctl_r[3][`DMC_F_EN], ctl_r[2][`DMC_F_EN], ctl_r[1][`DMC_F_EN], ctl_r[0][`DMC_F_EN]};
	wire [7:0] g_word =
		(off == `DMC_G_CTRL) ? gctl_r :
		(off == `DMC_G_STAT) ? stat_r :
		(off == `DMC_G_MASK) ? mask_r :
		(off == `DMC_G_BUSY) ? {pend_r, en_v} : 8'h00;
	wire [7:0] rd_word = g_hit ? g_word : c_hit ? c_word : 8'h00;

	// ----------------------------------------
	// Engine decode.
	// ----------------------------------------
	wire [15:0] cur_sa  = sa_r[ch_r];
	wire [15:0] cur_da  = da_r[ch_r];
	wire [7:0]  cur_ctl = ctl_r[ch_r];
	wire [7:0]  cur_amc = amc_r[ch_r];
	// The core wins unless the engine was turned away last time; that strict
	// alternation bounds the wait of either side to one bus cycle.
	wire        win      = !cpu_req || turn_r; // [R13] [R10]
	wire        src_bad  = in_fl(cur_sa) || (in_ee(cur_sa) && !ee_mapped); // [R9]
	wire        dst_bad  = in_fl(cur_da) || in_ee(cur_da); // [R9]
	wire        abort_rd = st_r == dmc_pkg::st_rd && src_bad; // [R15]
	wire        abort_wr = st_r == dmc_pkg::st_wr && dst_bad; // [R15]
	wire        err_ev   = abort_rd || abort_wr;
	wire        byte_done = st_r == dmc_pkg::st_wr && !dst_bad && win;
	wire        blk_end  = cnt_r[ch_r] == 16'h0001;
	wire        last     = blk_end && (!cur_ctl[`DMC_F_RPT] || rep_r[ch_r] == 8'h01);
	wire        done_ev  = byte_done && last;
	wire        quit     = st_r == dmc_pkg::st_rd && !cur_ctl[`DMC_F_EN];
	wire [3:0]  req      = (st_r == dmc_pkg::st_idle && gctl_r[`DMC_F_GEN]) ? (pend_r & en_v) : 4'h0;
	wire [1:0]  arb_gnt;
	wire        arb_vld;
	wire        start    = arb_vld && st_r == dmc_pkg::st_idle;
	wire [1:0]  blsel    = ctl_r[arb_gnt][`DMC_F_BL];
	wire [3:0]  blen     = (blsel == 2'h0) ? 4'h1 : (blsel == 2'h1) ? 4'h2 : (blsel == 2'h2) ? 4'h4 : 4'h8; // [R6]

	dmc_arb u_arb (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.req     (req),
		.rr_mode (gctl_r[`DMC_F_RR]),
		.take    (start),
		.gnt     (arb_gnt),
		.vld     (arb_vld)
	);

	// ----------------------------------------
	// Engine next state.
	// ----------------------------------------
	dmc_pkg::dmc_state_type st_nxt;
	logic [1:0]  ch_nxt;
	logic [3:0]  bl_nxt;
	logic [7:0]  data_nxt;
	logic        turn_nxt;
	logic [15:0] ba_nxt;
	logic [7:0]  bd_nxt;
	logic        bw_nxt;
	logic        brd_nxt;

	// Read one byte, wait a cycle for it, hold it, write it; repeat per burst.
	always_comb begin
		st_nxt = st_r;
		ch_nxt = ch_r;
		bl_nxt = bl_r;
		data_nxt = data_r;
		turn_nxt = turn_r;
		ba_nxt = 16'h0000;
		bd_nxt = 8'h00;
		bw_nxt = 1'b0;
		brd_nxt = 1'b0;
		case (st_r)
			dmc_pkg::st_idle: if (start) begin
				st_nxt = dmc_pkg::st_rd;
				ch_nxt = arb_gnt;
				bl_nxt = blen; // [R6]
			end
			dmc_pkg::st_rd: if (abort_rd || quit) begin
				st_nxt = dmc_pkg::st_idle;
			end else if (win) begin
				brd_nxt = 1'b1;
				ba_nxt = cur_sa; // [R12]
				turn_nxt = 1'b0;
				st_nxt = dmc_pkg::st_rwait;
			end else begin
				turn_nxt = 1'b1; // [R13]
			end
			dmc_pkg::st_rwait: st_nxt = dmc_pkg::st_latch;
			dmc_pkg::st_latch: begin
				data_nxt = bus_rdata;
				st_nxt = dmc_pkg::st_wr;
			end
			dmc_pkg::st_wr: if (abort_wr) begin
				st_nxt = dmc_pkg::st_idle;
			end else if (win) begin
				bw_nxt = 1'b1;
				ba_nxt = cur_da; // [R12]
				bd_nxt = data_r;
				turn_nxt = 1'b0;
				bl_nxt = bl_r - 4'h1;
				st_nxt = (bl_r != 4'h1 && !blk_end) ? dmc_pkg::st_rd : dmc_pkg::st_idle;
			end else begin
				turn_nxt = 1'b1; // [R13]
			end
			default: st_nxt = dmc_pkg::st_idle;
		endcase
	end

	// Engine and bus output flops.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= dmc_pkg::st_idle;
			{ch_r, bl_r, data_r, turn_r} <= 15'h0000;
			{ba_r, bd_r, bw_r, brd_r, own_r} <= 27'h000_0000;
		end else begin
			st_r <= st_nxt;
			{ch_r, bl_r, data_r, turn_r} <= {ch_nxt, bl_nxt, data_nxt, turn_nxt};
			{ba_r, bd_r, bw_r, brd_r, own_r} <= {ba_nxt, bd_nxt, bw_nxt, brd_nxt, bw_nxt | brd_nxt};
		end
	end

	// ----------------------------------------
	// Global registers, flags and interrupt.
	// ----------------------------------------
	// A flag raised in the cycle software clears it survives.
	wire [7:0] st_set  = {3'h0, err_ev, 3'h0, done_ev} << ch_r; // [R14] [R15]
	wire [7:0] st_clr  = (g_wr && off == `DMC_G_STAT) ? reg_wdata : 8'h00;
	wire [7:0] st_nxt8 = (stat_r & ~st_clr) | st_set;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			{gctl_r, stat_r, mask_r, rdata_r, irq_r} <= 33'h0_0000_0000;
		end else begin
			if (g_wr && off == `DMC_G_CTRL)
				gctl_r <= reg_wdata;
			if (g_wr && off == `DMC_G_MASK)
				mask_r <= reg_wdata;
			stat_r <= st_nxt8;
			irq_r <= |(st_nxt8 & mask_r);
			rdata_r <= reg_rd ? rd_word : 8'h00;
		end
	end

	// ----------------------------------------
	// Channel registers.
	// ----------------------------------------
	// Software writes first, engine updates after, so the engine's counts win.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pend_r <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				{ctl_r[i], amc_r[i], tsel_r[i], rp_r[i], rep_r[i]} <= 40'h00_0000_0000;
				{bk_r[i], cnt_r[i], sa0_r[i], sa_r[i], da0_r[i], da_r[i]} <= {6{`DMC_RST16}};
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (reg_wr && c_hit && c_ix == 2'(i)) begin // [R1]
					case (off)
						`DMC_C_CTRL: begin
							ctl_r[i] <= reg_wdata & 8'h3B;
							if (reg_wdata[`DMC_F_EN] && !ctl_r[i][`DMC_F_EN]) begin
								cnt_r[i] <= bk_r[i];
								rep_r[i] <= rp_r[i];
							end
						end
						`DMC_C_AMODE: amc_r[i] <= reg_wdata; // [R4]
						`DMC_C_TSEL:  tsel_r[i] <= reg_wdata; // [R11]
						`DMC_C_CNTL:  {bk_r[i][7:0], cnt_r[i][7:0]} <= {2{reg_wdata}}; // [R2]
						`DMC_C_CNTH:  {bk_r[i][15:8], cnt_r[i][15:8]} <= {2{reg_wdata}};
						`DMC_C_REP:   {rp_r[i], rep_r[i]} <= {2{reg_wdata}}; // [R3]
						`DMC_C_SRCL:  {sa0_r[i][7:0], sa_r[i][7:0]} <= {2{reg_wdata}};
						`DMC_C_SRCH:  {sa0_r[i][15:8], sa_r[i][15:8]} <= {2{reg_wdata}};
						`DMC_C_DSTL:  {da0_r[i][7:0], da_r[i][7:0]} <= {2{reg_wdata}};
						`DMC_C_DSTH:  {da0_r[i][15:8], da_r[i][15:8]} <= {2{reg_wdata}};
						default: ;
					endcase
				end
				// Pending burst request; a new trigger beats the start-of-burst clear.
				pend_r[i] <= ctl_r[i][`DMC_F_EN] && ((pend_r[i] && !(start && arb_gnt == 2'(i)))
					|| trig_hit(tsel_r[i], evt_trig, per_trig[8*i +: 8])
					|| (reg_wr && c_hit && c_ix == 2'(i) && off == `DMC_C_CTRL && reg_wdata[`DMC_F_SWRQ])); // [R11]
				if (byte_done && ch_r == 2'(i)) begin
					sa_r[i] <= step(sa_r[i], amc_r[i][`DMC_F_SMODE]); // [R4]
					da_r[i] <= step(da_r[i], amc_r[i][`DMC_F_DMODE]); // [R4]
					cnt_r[i] <= blk_end ? bk_r[i] : cnt_r[i] - 16'h0001; // [R2]
					if (blk_end)
						rep_r[i] <= last ? rp_r[i] : rep_r[i] - 8'h01; // [R3]
					if (last) begin
						ctl_r[i][`DMC_F_EN] <= 1'b0; // [R14]
						if (amc_r[i][`DMC_F_SRLD])
							sa_r[i] <= sa0_r[i]; // [R5]
						if (amc_r[i][`DMC_F_DRLD])
							da_r[i] <= da0_r[i]; // [R5]
					end
				end
				// The partner of a finished linked channel is armed to carry on.
				if (done_ev && ch_r == 2'(i ^ 1) && cur_ctl[`DMC_F_LINK]) begin
					ctl_r[i][`DMC_F_EN] <= 1'b1; // [R8]
					cnt_r[i] <= bk_r[i];
					rep_r[i] <= rp_r[i];
				end
				if (err_ev && ch_r == 2'(i))
					ctl_r[i][`DMC_F_EN] <= 1'b0; // [R15]
			end
		end
	end

	// ----------------------------------------
	// Outputs.
	// ----------------------------------------
	assign reg_rdata = rdata_r;
	assign bus_addr  = ba_r;
	assign bus_wdata = bd_r;
	assign bus_wr    = bw_r;
	assign bus_rd    = brd_r;
	assign dma_own   = own_r;
	assign irq       = irq_r;

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	chan_isolated_a: assert property ( // [R1]
		!(reg_wr && c_hit && c_ix == 2'h0) |=> $stable(amc_r[0]) && $stable(tsel_r[0]))
		else $error("channel zero changed by another access");
	block_reload_a: assert property ( // [R2]
		(byte_done && blk_end && !last) |=> cnt_r[$past(ch_r)] == bk_r[$past(ch_r)])
		else $error("block count not reloaded");
	repeat_dec_a: assert property ( // [R3]
		(byte_done && blk_end && !last) |=> rep_r[$past(ch_r)] == $past(rep_r[ch_r]) - 8'h01)
		else $error("repeat count not decremented");
	fixed_src_a: assert property ( // [R4]
		(byte_done && !last && cur_amc[1:0] == 2'h0) |=> sa_r[$past(ch_r)] == $past(cur_sa))
		else $error("fixed source address moved");
	addr_reload_a: assert property ( // [R5]
		(done_ev && cur_amc[`DMC_F_SRLD]) |=> sa_r[$past(ch_r)] == sa0_r[$past(ch_r)])
		else $error("source address not reloaded");
	burst_len_a: assert property ( // [R6]
		start |=> $onehot(bl_r) && bl_r <= 4'h8)
		else $error("illegal burst length");
	link_hand_a: assert property ( // [R8]
		(done_ev && cur_ctl[`DMC_F_LINK]) |=> ctl_r[$past(ch_r) ^ 2'h1][`DMC_F_EN])
		else $error("linked partner not armed");
	no_bad_write_a: assert property ( // [R9]
		bus_wr |-> !in_ee(bus_addr) && !in_fl(bus_addr))
		else $error("write to protected memory");
	core_first_a: assert property ( // [R13]
		(st_r == dmc_pkg::st_rd && cpu_req && !turn_r && !src_bad && cur_ctl[0]) |=> !bus_rd ##1 bus_rd)
		else $error("bus alternation broken");
	trig_pend_a: assert property ( // [R11]
		(ctl_r[0][0] && trig_hit(tsel_r[0], evt_trig, per_trig[7:0])) |=> pend_r[0])
		else $error("trigger lost");
	done_stop_a: assert property ( // [R14]
		done_ev |=> stat_r[$past(ch_r)] && !ctl_r[$past(ch_r)][0])
		else $error("completion not flagged");
	abort_err_a: assert property ( // [R15]
		err_ev |=> stat_r[$past(ch_r) + 3'h4] && st_r == dmc_pkg::st_idle && !bus_rd)
		else $error("abort not flagged");

	burst_seen_c: cover property (start ##1 bl_r == 4'h8);
	link_seen_c:  cover property (done_ev && cur_ctl[`DMC_F_LINK]);
	abort_seen_c: cover property (abort_wr);
	wait_seen_c:  cover property (turn_r ##1 bus_rd);

endmodule

// ===== testbench/dmc_mem_model.sv
`timescale 1ns/1ps

// Byte-wide memory and I/O space standing on the shared data bus.
module dmc_mem_model (
	// Clock.
	input  wire logic        sys_clk,
	// Data bus from the controller.
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	// Memory map state.
	input  wire logic        ee_mapped,
	output logic      [7:0]  bus_rdata
);
	logic [7:0]  mem [0:65535];
	logic [15:0] rd_log [$];
	int          wr_cnt;
	int          bad_cnt;
	wire         ee_hit = (bus_addr >= 16'h1000) && (bus_addr <= 16'h1FFF);
	wire         fl_hit = bus_addr >= 16'hF000;

	// Every location starts from a pattern of its own address.
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
		end
		bus_rdata = 8'h00;
		wr_cnt    = 0;
		bad_cnt   = 0;
	end

	// Read data stand only in the cycle after the strobe; otherwise the lines toggle so stale data never passes.
	always @(posedge sys_clk) begin
		if (bus_rd) begin
			bus_rdata <= mem[bus_addr];
			rd_log.push_back(bus_addr);
		end else begin
			bus_rdata <= ~bus_rdata;
		end
		if (bus_wr) begin
			mem[bus_addr] <= bus_wdata;
			wr_cnt        <= wr_cnt + 1;
		end
	end

	// Counts every access into a window that the controller must leave alone.
	always @(posedge sys_clk) begin
		if ((bus_wr && (ee_hit || fl_hit)) || (bus_rd && (fl_hit || (ee_hit && !ee_mapped)))) begin
			bad_cnt <= bad_cnt + 1;
		end
	end
endmodule

// ===== testbench/dmc_core_tb.sv
`timescale 1ns/1ps

module dmc_core_tb;
	logic        sys_clk;
	logic        rstn;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic [7:0]  evt_trig;
	logic [31:0] per_trig;
	logic        cpu_req;
	logic        ee_mapped;
	logic [7:0]  bus_rdata;
	logic [15:0] bus_addr;
	logic [7:0]  bus_wdata;
	logic        bus_wr;
	logic        bus_rd;
	logic        dma_own;
	logic        irq;
	int          miscompares;
	int          checked;
	logic [7:0]  d;
	int          w0;

	dmc_core u_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_trig(evt_trig), .per_trig(per_trig),
		.cpu_req(cpu_req), .ee_mapped(ee_mapped), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .dma_own(dma_own), .irq(irq));

	dmc_mem_model u_mem (.sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .ee_mapped(ee_mapped), .bus_rdata(bus_rdata));

	// 25 MHz system clock.
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// Bus tasks and comparison.
	// ----------------------------------------
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask

	// Read data are only valid in the cycle after the strobe, so sample just after that edge.
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task rchk(input logic [7:0] a, input logic [7:0] exp);
		rd(a, d);
		chk(d, exp);
	endtask

	task cfg(input logic [7:0] b, input logic [15:0] s, input logic [15:0] t, input logic [15:0] n,
		input logic [7:0] rep, input logic [7:0] am, input logic [7:0] ts);
		wr(b + 8'h01, am);
		wr(b + 8'h02, ts);
		wr(b + 8'h03, n[7:0]);
		wr(b + 8'h04, n[15:8]);
		wr(b + 8'h05, rep);
		wr(b + 8'h06, s[7:0]);
		wr(b + 8'h07, s[15:8]);
		wr(b + 8'h08, t[7:0]);
		wr(b + 8'h09, t[15:8]);
	endtask

	// Polls status until all bits of the mask are set; the bound stops a hang.
	task wait_done(input logic [7:0] m);
		for (int i = 0; i < 100; i++) begin
			rd(8'h01, d);
			if ((d & m) === m) break;
		end
	endtask

	task wait_wr(input int n);
		for (int i = 0; i < 200; i++) begin
			@(posedge sys_clk);
			if (u_mem.wr_cnt == n) break;
		end
	endtask

	// Quiet window long enough for several byte transfers to have shown up.
	task idle;
		repeat (30) @(posedge sys_clk);
	endtask

	// The bus-ownership flag must cover exactly the controller's own strobes.
	always @(negedge sys_clk) begin
		if (rstn === 1'b1) chk(dma_own, bus_rd | bus_wr);
	end

	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task automatic t_reset;
		logic [7:0] al [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h23, 8'h49, 8'h0A, 8'h5A};
		foreach (al[i]) rchk(al[i], 8'h00);
		wr(8'h5A, 8'hFF);
		rchk(8'h5A, 8'h00);
		wr(8'h13, 8'h77);
		rchk(8'h23, 8'h00);
	endtask

	task t_basic;
		wr(8'h00, 8'h01);
		wr(8'h02, 8'h0F);
		cfg(8'h10, 16'h2000, 16'h3000, 16'h0005, 8'h01, 8'h11, 8'h00);
		wr(8'h10, 8'h31);
		wr(8'h10, 8'h35);
		wait_done(8'h01);
		for (int i = 0; i < 5; i++) chk(u_mem.mem[16'h3000 + i], pat(16'h2000 + i));
		chk(irq, 1'b1);
		rchk(8'h10, 8'h30);
		rchk(8'h03, 8'h00);
		wr(8'h02, 8'h00);
		rchk(8'h01, 8'h01);
		chk(irq, 1'b0);
		wr(8'h02, 8'h0F);
		wr(8'h01, 8'h01);
		rchk(8'h01, 8'h00);
		chk(irq, 1'b0);
	endtask

	// Single-byte bursts, decrementing source into a fixed destination.
	task t_modes;
		cfg(8'h20, 16'h2103, 16'h3100, 16'h0003, 8'h01, 8'h02, 8'h00);
		w0 = u_mem.wr_cnt;
		wr(8'h20, 8'h01);
		for (int k = 1; k <= 3; k++) begin
			wr(8'h20, 8'h05);
			wait_wr(w0 + k);
			idle;
			chk(16'(u_mem.wr_cnt - w0), 16'(k));
			chk(u_mem.mem[16'h3100], pat(16'h2104 - 16'(k)));
		end
		wait_done(8'h02);
		rchk(8'h26, 8'h00);
		rchk(8'h27, 8'h21);
		rchk(8'h28, 8'h00);
		wr(8'h01, 8'h02);
	endtask

	// Two blocks of two bytes, each block needing its own trigger, then address reload.
	task t_repeat;
		cfg(8'h30, 16'h2200, 16'h3200, 16'h0002, 8'h02, 8'h55, 8'h00);
		w0 = u_mem.wr_cnt;
		wr(8'h30, 8'h33);
		wr(8'h30, 8'h37);
		wait_wr(w0 + 2);
		idle;
		chk(16'(u_mem.wr_cnt - w0), 16'h0002);
		rchk(8'h01, 8'h00);
		wr(8'h30, 8'h37);
		wait_done(8'h04);
		for (int i = 0; i < 4; i++) chk(u_mem.mem[16'h3200 + i], pat(16'h2200 + i));
		rchk(8'h36, 8'h00);
		rchk(8'h37, 8'h22);
		rchk(8'h38, 8'h00);
		rchk(8'h39, 8'h32);
		wr(8'h01, 8'h04);
	endtask

	// Only the selected event and peripheral lines may start a burst.
	task t_trig;
		cfg(8'h20, 16'h2300, 16'h3300, 16'h0002, 8'h01, 8'h11, 8'hC3);
		w0 = u_mem.wr_cnt;
		wr(8'h20, 8'h01);
		@(posedge sys_clk);
		evt_trig <= 8'h04;
		per_trig <= 32'h0000_0400;
		@(posedge sys_clk);
		evt_trig <= 8'h00;
		per_trig <= 32'h0000_0000;
		idle;
		chk(16'(u_mem.wr_cnt - w0), 16'h0000);
		evt_trig <= 8'h08;
		@(posedge sys_clk);
		evt_trig <= 8'h00;
		wait_wr(w0 + 1);
		chk(16'(u_mem.wr_cnt - w0), 16'h0001);
		per_trig <= 32'h0000_0800;
		@(posedge sys_clk);
		per_trig <= 32'h0000_0000;
		wait_done(8'h02);
		chk(u_mem.mem[16'h3301], pat(16'h2301));
		wr(8'h01, 8'h02);
	endtask

	// Unmapped EEPROM read, mapped EEPROM read, EEPROM write, flash read.
	task automatic t_forbid;
		logic [15:0] fs [4] = '{16'h1000, 16'h1010, 16'h2400, 16'hF000};
		logic [15:0] fd [4] = '{16'h3400, 16'h3400, 16'h1000, 16'h3400};
		for (int i = 0; i < 4; i++) begin
			ee_mapped <= (i != 0);
			cfg(8'h40, fs[i], fd[i], 16'h0001, 8'h01, 8'h11, 8'h00);
			wr(8'h40, 8'h01);
			wr(8'h40, 8'h05);
			wait_done((i != 1) ? 8'h80 : 8'h08);
			rchk(8'h01, (i != 1) ? 8'h80 : 8'h08);
			rchk(8'h40, 8'h00);
			wr(8'h01, 8'h88);
		end
		chk(u_mem.mem[16'h3400], pat(16'h1010));
		chk(16'(u_mem.bad_cnt), 16'h0000);
	endtask

	task t_prio_link;
		wr(8'h00, 8'h00);
		cfg(8'h10, 16'h2500, 16'h3500, 16'h0001, 8'h01, 8'h11, 8'h00);
		cfg(8'h20, 16'h2600, 16'h3600, 16'h0001, 8'h01, 8'h11, 8'h00);
		wr(8'h20, 8'h01);
		wr(8'h20, 8'h05);
		wr(8'h10, 8'h01);
		wr(8'h10, 8'h05);
		u_mem.rd_log.delete();
		wr(8'h00, 8'h01);
		wait_done(8'h03);
		chk(u_mem.rd_log[0], 16'h2500);
		chk(u_mem.rd_log[1], 16'h2600);
		wr(8'h01, 8'h03);
		cfg(8'h20, 16'h2800, 16'h3800, 16'h0001, 8'h01, 8'h11, 8'h00);
		wr(8'h20, 8'h08);
		wr(8'h10, 8'h09);
		wr(8'h10, 8'h0D);
		wait_done(8'h01);
		rchk(8'h20, 8'h89);
		wr(8'h20, 8'h0D);
		wait_done(8'h02);
		chk(u_mem.mem[16'h3800], pat(16'h2800));
		rchk(8'h10, 8'h89);
		wr(8'h10, 8'h00);
		wr(8'h01, 8'h03);
	endtask

	// The core asks for the bus every cycle; the controller must still get its turns.
	task t_cpu;
		cpu_req <= 1'b1;
		cfg(8'h10, 16'h2900, 16'h3900, 16'h0002, 8'h01, 8'h11, 8'h00);
		wr(8'h10, 8'h31);
		wr(8'h10, 8'h35);
		wait_done(8'h01);
		chk(u_mem.mem[16'h3901], pat(16'h2901));
		cpu_req <= 1'b0;
		wr(8'h01, 8'h01);
	endtask

	// Round robin serves the channel after the last winner first; channel 0 reads a fixed source.
	task t_rr;
		wr(8'h00, 8'h00);
		cfg(8'h10, 16'h2A00, 16'h3A00, 16'h0002, 8'h01, 8'h10, 8'h00);
		cfg(8'h20, 16'h2B00, 16'h3B00, 16'h0001, 8'h01, 8'h11, 8'h00);
		wr(8'h10, 8'h11);
		wr(8'h10, 8'h15);
		wr(8'h20, 8'h01);
		wr(8'h20, 8'h05);
		u_mem.rd_log.delete();
		wr(8'h00, 8'h03);
		wait_done(8'h03);
		chk(u_mem.rd_log[0], 16'h2B00);
		chk(u_mem.rd_log[1], 16'h2A00);
		chk(u_mem.mem[16'h3A01], pat(16'h2A00));
		wr(8'h01, 8'h03);
	endtask

	// ----------------------------------------
	// Verdict and main sequence.
	// ----------------------------------------
	task end_of_test;
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		rstn        = 1'b0;
		reg_addr    = 8'h00;
		reg_wdata   = 8'h00;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		evt_trig    = 8'h00;
		per_trig    = 32'h0000_0000;
		cpu_req     = 1'b0;
		ee_mapped   = 1'b0;
		miscompares = 0;
		checked     = 0;
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset;
		t_basic;
		t_modes;
		t_repeat;
		t_trig;
		t_forbid;
		t_prio_link;
		t_cpu;
		t_rr;
		end_of_test;
	end

	// The whole run needs under a thousand cycles; this limit of 30000 cycles is far beyond that.
	initial begin
		#(40 * 30000);
		miscompares++;
		end_of_test;
	end
endmodule
